// >>> src/emsd_defs.svh
`ifndef EMSD_DEFS_SVH
`define EMSD_DEFS_SVH

`define EMSD_ADDR_W        24
`define EMSD_NUM_CHAN      3
`define EMSD_CH0_LO_RST    24'h1F2000
`define EMSD_CH0_HI_RST    24'h1F20FF
`define EMSD_CHX_LO_RST    24'h000000
`define EMSD_CHX_HI_RST    24'h000000
`define EMSD_WAIT_RST      2'h3
`define EMSD_WIDTH16_RST   1'h1
`define EMSD_FLASH_LO      24'hFC0000
`define EMSD_FLASH_HI      24'hFFFFFF
`define EMSD_DEFAULT_CHAN  2'h2
`define EMSD_STRAP_SETTLE  2'h3

`endif

// >>> src/emsd_pkg.sv
`include "emsd_defs.svh"

package emsd_pkg;
  typedef logic [`EMSD_ADDR_W-1:0] emsd_addr_t;
  typedef logic [1:0]              emsd_chan_t;
  typedef logic [1:0]              emsd_wait_t;
endpackage

// >>> src/emsd_sync.sv
`timescale 1ns/1ns

// Three-stage pin synchroniser; stable when the last two stages agree
module emsd_sync (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      stable_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign level_out  = s3_reg;
  assign stable_out = (s2_reg == s3_reg);
endmodule

// >>> src/emsd_decode.sv
`timescale 1ns/1ns
`include "emsd_defs.svh"

// Contract
// R1: Each channel whose range holds the external address drives its select low.
// R2: Address in no range asserts no select and uses channel two bus settings.
// R3: After reset channel zero covers 1F2000-1F20FF, others disabled.
// R4: Flash region FC0000-FFFFFF is internal if strap high, external if low.
// R5: Outside the flash region the strap level is ignored.
// R6: Strap captured once at reset release and held until the next reset.
module emsd_decode
  import emsd_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       flash_region_external_strap_n_in,
  input  wire logic       access_valid_in,
  input  wire emsd_addr_t access_addr_in,
  input  wire logic       cfg_write_in,
  input  wire emsd_chan_t cfg_chan_in,
  input  wire logic       cfg_enable_in,
  input  wire emsd_addr_t cfg_lo_in,
  input  wire emsd_addr_t cfg_hi_in,
  input  wire emsd_wait_t cfg_wait_in,
  input  wire logic       cfg_width16_in,
  output logic            ready_out,
  output logic [2:0]      select_lines_n_out,
  output logic            cycle_external_out,
  output logic            cycle_internal_flash_out,
  output emsd_wait_t      cycle_wait_out,
  output logic            cycle_width16_out
);
  logic            chan_en_reg   [`EMSD_NUM_CHAN];
  emsd_addr_t      chan_lo_reg   [`EMSD_NUM_CHAN];
  emsd_addr_t      chan_hi_reg   [`EMSD_NUM_CHAN];
  emsd_wait_t      chan_wait_reg [`EMSD_NUM_CHAN];
  logic            chan_w16_reg  [`EMSD_NUM_CHAN];
  logic            strap_reg;
  logic            latched_reg;
  logic [1:0]      settle_reg;
  logic            ready_reg;
  logic [2:0]      sel_n_reg;
  logic            ext_reg;
  logic            intf_reg;
  emsd_wait_t      wait_reg;
  logic            w16_reg;
  logic            strap_level;
  logic            strap_stable;
  logic [2:0]      hit;
  logic            in_flash;
  logic            go_internal;
  logic            go_external;
  emsd_chan_t      cfg_sel;

  function automatic logic in_range(input emsd_addr_t a,
                                    input emsd_addr_t lo,
                                    input emsd_addr_t hi,
                                    input logic       en);
    in_range = en && (a >= lo) && (a <= hi);
  endfunction

  emsd_sync u_strap_sync (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .pin_in     (flash_region_external_strap_n_in),
    .level_out  (strap_level),
    .stable_out (strap_stable)
  );

  // Capture once the chain has filled and settled, then freeze
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      settle_reg  <= 2'h0;
      latched_reg <= 1'h0;
      strap_reg   <= 1'h1;
    end else if (!latched_reg) begin
      if (settle_reg != `EMSD_STRAP_SETTLE) begin
        settle_reg <= settle_reg + 2'h1;
      end else if (strap_stable) begin
        latched_reg <= 1'h1; // [R6]
        strap_reg   <= strap_level; // [R6]
      end
    end
  end

  assign in_flash = (access_addr_in >= `EMSD_FLASH_LO) &&
                    (access_addr_in <= `EMSD_FLASH_HI);
  // Strap only matters inside the flash window
  assign go_internal = in_flash && strap_reg; // [R4] [R5]
  assign go_external = access_valid_in && latched_reg && !go_internal; // [R4]

  genvar g;
  generate
    for (g = 0; g < `EMSD_NUM_CHAN; g++) begin : g_hit
      assign hit[g] = in_range(access_addr_in, chan_lo_reg[g],
                               chan_hi_reg[g], chan_en_reg[g]); // [R1]
    end
  endgenerate

  // Overlaps: lowest channel supplies bus settings; a miss uses channel two
  assign cfg_sel = hit[0] ? 2'h0 :
                   hit[1] ? 2'h1 : `EMSD_DEFAULT_CHAN; // [R2]

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < `EMSD_NUM_CHAN; i++) begin
        chan_en_reg[i]   <= (i == 0); // [R3]
        chan_lo_reg[i]   <= (i == 0) ? `EMSD_CH0_LO_RST
                                     : `EMSD_CHX_LO_RST; // [R3]
        chan_hi_reg[i]   <= (i == 0) ? `EMSD_CH0_HI_RST
                                     : `EMSD_CHX_HI_RST; // [R3]
        chan_wait_reg[i] <= `EMSD_WAIT_RST;
        chan_w16_reg[i]  <= `EMSD_WIDTH16_RST;
      end
    end else if (cfg_write_in && cfg_chan_in != 2'h3) begin
      chan_en_reg[cfg_chan_in]   <= cfg_enable_in;
      chan_lo_reg[cfg_chan_in]   <= cfg_lo_in;
      chan_hi_reg[cfg_chan_in]   <= cfg_hi_in;
      chan_wait_reg[cfg_chan_in] <= cfg_wait_in;
      chan_w16_reg[cfg_chan_in]  <= cfg_width16_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ready_reg <= 1'h0;
      sel_n_reg <= 3'h7;
      ext_reg   <= 1'h0;
      intf_reg  <= 1'h0;
      wait_reg  <= `EMSD_WAIT_RST;
      w16_reg   <= `EMSD_WIDTH16_RST;
    end else begin
      ready_reg <= latched_reg;
      sel_n_reg <= go_external ? ~hit : 3'h7; // [R1] [R2]
      ext_reg   <= go_external;
      intf_reg  <= access_valid_in && latched_reg && go_internal; // [R4]
      wait_reg  <= chan_wait_reg[cfg_sel]; // [R2]
      w16_reg   <= chan_w16_reg[cfg_sel]; // [R2]
    end
  end

  assign ready_out                = ready_reg;
  assign select_lines_n_out       = sel_n_reg;
  assign cycle_external_out       = ext_reg;
  assign cycle_internal_flash_out = intf_reg;
  assign cycle_wait_out           = wait_reg;
  assign cycle_width16_out        = w16_reg;
endmodule

// >>> dv/emsd_chk.sv
`timescale 1ns/1ns
module emsd_chk
  import emsd_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       flash_region_external_strap_n_in,
  input wire logic       access_valid_in,
  input wire emsd_addr_t access_addr_in,
  input wire logic       ready_out,
  input wire logic [2:0] select_lines_n_out,
  input wire logic       cycle_external_out,
  input wire logic       cycle_internal_flash_out
);
  logic      sr;
  wire       fl = access_addr_in >= 24'hFC0000;
  wire       vv = access_valid_in && ready_out;
  wire       xt = cycle_external_out;
  wire       it = cycle_internal_flash_out;
  wire [2:0] sl = select_lines_n_out;
  // Pin trusted only until ready shows the latch is done
  always_ff @(posedge clk_in)
    if (!ready_out) sr <= flash_region_external_strap_n_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_CH0_HIT: assert property (
    vv && access_addr_in inside {[24'h1F2000:24'h1F20FF]} |=> !sl[0] && xt)
    else $error("channel zero not selected");
  AST_NO_ACC: assert property (
    !access_valid_in |=> sl == 3'h7 && !xt && !it)
    else $error("select without access");
  AST_FL_INT: assert property (
    vv && fl && sr |=> it && !xt && sl == 3'h7)
    else $error("flash not internal");
  AST_FL_EXT: assert property (
    vv && fl && !sr |=> xt && !it)
    else $error("flash not external");
  AST_NON_FL: assert property (
    vv && !fl |=> xt && !it)
    else $error("strap used outside flash");
  AST_RDY_HOLD: assert property (
    ready_out |=> ready_out)
    else $error("ready dropped");
  cover property (vv && fl && sr);
  cover property (vv && fl && !sr);
  cover property (vv && !fl);
endmodule

bind emsd_decode emsd_chk u_emsd_chk(.clk_in, .reset_in,
  .flash_region_external_strap_n_in, .access_valid_in, .access_addr_in,
  .ready_out, .select_lines_n_out, .cycle_external_out,
  .cycle_internal_flash_out);

// >>> dv/emsd_mem.sv
`timescale 1ns/1ns
// Counts cycles in which any memory device is selected
module emsd_mem (
  input  wire logic       clk_in,
  input  wire logic [2:0] sel_n_in,
  output int              hits_out
);
  initial hits_out = 0;
  always @(posedge clk_in) if (sel_n_in != 3'h7) hits_out <= hits_out + 1;
endmodule

// >>> dv/external_memory_select_decode_tb.sv
`timescale 1ns/1ns
module external_memory_select_decode_tb;
  import emsd_pkg::*;
  logic clk_in = 0, reset_in = 0, st = 1, v = 0, cw = 0, w16 = 0, vd = 0;
  logic en = 1;
  logic [1:0] ch = 0, wt = 0;
  emsd_addr_t a = 0, lo = 0, hi = 0, ra;
  logic [2:0] sel;
  logic ext, itf, w16o, rdy;
  emsd_wait_t wo;
  logic [7:0] q[$];
  int n_errors = 0, check_count = 0, cyc = 0, seed = 39, hits, nsel = 0;
  emsd_decode u_emsd_decode(.clk_in, .reset_in,
    .flash_region_external_strap_n_in(st), .access_valid_in(v),
    .access_addr_in(a), .cfg_write_in(cw), .cfg_chan_in(ch),
    .cfg_enable_in(en), .cfg_lo_in(lo), .cfg_hi_in(hi),
    .cfg_wait_in(wt), .cfg_width16_in(w16), .ready_out(rdy),
    .select_lines_n_out(sel), .cycle_external_out(ext),
    .cycle_internal_flash_out(itf), .cycle_wait_out(wo),
    .cycle_width16_out(w16o));
  emsd_mem u_emsd_mem(.clk_in, .sel_n_in(sel), .hits_out(hits));
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input emsd_addr_t ad, input logic [7:0] e);
    @(posedge clk_in);
    v <= 1;
    a <= ad;
    q.push_back(e);
    if (e[7:5] != 3'h7) nsel++;
  endtask
  task automatic cfg(input logic [1:0] c, input emsd_addr_t l, input emsd_addr_t h,
                     input logic [1:0] w, input logic b);
    @(posedge clk_in);
    {v, cw, ch, lo, hi, wt, w16} <= {2'b01, c, l, h, w, b};
    @(posedge clk_in);
    cw <= 0;
  endtask
  task automatic rst(input logic s);
    @(posedge clk_in);
    v <= 0;
    @(posedge clk_in);
    reset_in <= 1;
    st <= s;
    repeat (8) @(posedge clk_in);
    reset_in <= 0;
    acc(24'h1F2010, 8'hE7);
    acc(24'h1F2010, 8'hE7);
    @(posedge clk_in);
    v <= 0;
    @(posedge clk_in);
    #1 chk(8'(rdy), 8'h00);
    @(posedge clk_in);
    #1 chk(8'(rdy), 8'h01);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_in) vd <= v && !reset_in;
  always @(negedge clk_in) if (vd) chk({sel, ext, itf, wo, w16o}, q.pop_front());
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    reset_in <= 1;
    rst(1);
    acc(24'h1F2000, 8'hD7);
    acc(24'h1F20FF, 8'hD7);
    acc(24'h1F2100, 8'hF7);
    acc(24'hFC0000, 8'hEF);
    acc(24'hFFFFFF, 8'hEF);
    cfg(1, 24'h0, 24'hFF, 2, 1);
    cfg(2, 24'h1F2000, 24'h1F2000, 1, 0);
    cfg(3, 24'h0, 24'hFFFFFF, 0, 0);
    acc(24'h0, 8'hB5);
    acc(24'h100, 8'hF2);
    acc(24'h1F2000, 8'h57);
    repeat (16) begin
      ra = 24'($random(seed)) & 24'h1FF;
      acc(ra, ra <= 24'hFF ? 8'hB5 : 8'hF2);
    end
    en <= 0;
    cfg(1, 24'h0, 24'hFF, 2, 1);
    acc(24'h10, 8'hF2);
    st <= 0;
    acc(24'hFC0000, 8'hEA);
    rst(0);
    acc(24'hFFFFFF, 8'hF7);
    acc(24'h1F2010, 8'hD7);
    rst(1);
    chk(8'(hits), 8'(nsel));
    test_done();
  end
endmodule
